// *** logic/dra_read_ack_top.sv ***
// Receive parser, read answer and error report of the serial display link.
// How it works
// - Short type 06h is a parameterless read.
// - Only listed read commands are executed.
// - First fetched byte is dummy, dropped.
// - Return size is the two data bytes.
// - All packets use virtual channel zero.
// - After turnaround send report or data.
// - Null long packets are checked, discarded.
// - End packet: type 08h, 0F 0F, 01.
// - Bursts with or without end packets work.
// - Missing end packet in an HS burst flags protocol violation.
// - Reporting fixed by static configuration input.
// - Device never sends end packets, no HS.
// - Answer fits one packet, never split.
// - Corrected read: data first, then report.
// - Report is short type 02h, 16 bits.
// - Bits 0-7 are lane-level errors.
// - Bits 8-10: ECC single, multi, checksum.
// - Bits 11-13 type, channel, protocol; 14 zero.
// - Packets with a multi-bit or channel error are never executed.
// - Checksum CRC16, seed ones, LSB first.
`timescale 1ns/1ps
`include "dra_regs.svh"
module dra_read_ack_top
  import dra_pkg::*;
(
  input  wire logic       i_clock,
  input  wire logic       i_reset,
  input  wire logic       i_eotp_used,
  input  wire logic       i_report_en,
  input  wire logic       i_link_clock,
  input  wire logic [7:0] i_lnk_data,
  input  wire logic       i_lnk_valid,
  input  wire logic       i_lnk_hs,
  input  wire logic       i_lnk_eot,
  input  wire logic [7:0] i_lnk_phy_err,
  input  wire logic       i_lnk_bta,
  input  wire logic       i_tx_ready,
  input  wire logic       i_rd_valid,
  input  wire logic [7:0] i_rd_data,
  output logic [7:0]      o_tx_data,
  output logic            o_tx_valid,
  output logic            o_tx_last,
  output logic            o_rd_req,
  output logic [7:0]      o_rd_cmd,
  output logic [16:0]     o_rd_count,
  output logic            o_rd_pop,
  output logic            o_ack
);
  // Link-side state on the link clock; turn_word and turn_valid sit in the answer domain.
  logic        lrst_meta_reg, lrst_reg;   // Reset carried into link domain.
  logic        ecfg_meta_reg, ecfg_reg;   // End-packet usage, synchronised.
  dra_pstate_t p_state_reg, p_state_next; // Packet position.
  logic [15:0] p_cnt_reg, p_cnt_next;     // Byte index or bytes left.
  logic [23:0] hdr_reg, hdr_next;         // Header bytes gathered so far.
  logic [15:0] crc_reg, crc_next;         // Running payload checksum.
  logic [7:0]  fcs_reg, fcs_next;         // Low footer byte.
  logic [15:0] err_reg, err_next;         // Gathered error flags.
  logic        pend_reg, pend_next;       // A valid read is waiting.
  logic [7:0]  cmd_reg, cmd_next;         // Command of that read.
  logic [15:0] mrs_reg, mrs_next;         // Current max_return_size.
  logic        eots_reg, eots_next;       // Last packet was an end packet.
  logic        turn_load, sync_busy;      // Snapshot handed over.
  dra_ecc_res_t ecc_res;                  // Checked header word.
  dra_turn_t   turn_word;                 // Snapshot in the answer domain.
  logic        turn_valid;                // Snapshot arrival strobe.

  // Reset and the end-packet configuration pass two flops into the link domain.
  always_ff @(posedge i_link_clock) begin
    lrst_meta_reg <= i_reset;
    lrst_reg      <= lrst_meta_reg;
    ecfg_meta_reg <= i_eotp_used;
    ecfg_reg      <= ecfg_meta_reg;
  end

  // A turnaround while the previous snapshot is still in flight is lost;
  // the host cannot turn the bus round that fast in practice.
  assign turn_load = i_lnk_bta && !sync_busy;
  assign ecc_res = dra_ecc_fix(hdr_reg, i_lnk_data[5:0]);

  // Parser next-state: header, payload, footer, and error gathering.
  always_comb begin
    logic        bad;
    logic [23:0] w;
    bad = 1'b0;
    w = ecc_res.word;
    p_state_next = p_state_reg;
    p_cnt_next = p_cnt_reg;
    hdr_next = hdr_reg;
    crc_next = crc_reg;
    fcs_next = fcs_reg;
    // New events are ORed after the clear so none is lost.
    err_next = (turn_load ? 16'h0000 : err_reg)
               | {8'h00, i_lnk_phy_err};
    pend_next = turn_load ? 1'b0 : pend_reg;
    cmd_next = cmd_reg;
    mrs_next = mrs_reg;
    eots_next = eots_reg;
    if (i_lnk_valid) begin
      case (p_state_reg)
        P_HDR: begin
          if (p_cnt_reg[1:0] != `DRA_HDR_LAST) begin
            hdr_next = {i_lnk_data, hdr_reg[23:8]};
            p_cnt_next = p_cnt_reg + 16'h0001;
          end else begin
            p_cnt_next = 16'h0000;
            hdr_next = w;
            eots_next = 1'b0;
            if (ecc_res.multi) begin
              // Length is untrustworthy; nothing more can be parsed.
              err_next[`DRA_EB_ECC2] = 1'b1;
            end else begin
              if (ecc_res.single) err_next[`DRA_EB_ECC1] = 1'b1;
              if (w[7:6] != `DRA_VC_MAIN) begin
                err_next[`DRA_EB_VCID] = 1'b1;
                bad = 1'b1;
              end
              if (w[5:0] == `DRA_DT_NULL || w[5:0] == `DRA_DT_WRL) begin
                // Long packet: payload is only checked, then dropped.
                crc_next = `DRA_CRC_SEED;
                p_cnt_next = w[23:8];
                p_state_next = (w[23:8] == 16'h0000) ? P_FOOT : P_PAY;
              end else begin
                case (w[5:0])
                  `DRA_DT_READ: begin
                    if (!bad && dra_cmd_ok(w[15:8])) begin
                      pend_next = 1'b1;
                      cmd_next = w[15:8];
                    end
                  end
                  `DRA_DT_MAXRET: begin
                    if (!bad) mrs_next = w[23:8];
                  end
                  `DRA_DT_EOT: begin
                    if (w[23:8] != {`DRA_EOT_BYTE, `DRA_EOT_BYTE})
                      err_next[`DRA_EB_PROTO] = 1'b1;
                    else
                      eots_next = 1'b1;
                  end
                  `DRA_DT_WR0, `DRA_DT_WR1: begin
                    // Writes are executed elsewhere.
                  end
                  default: begin
                    err_next[`DRA_EB_DTYPE] = 1'b1;
                  end
                endcase
              end
            end
          end
        end
        P_PAY: begin
          crc_next = dra_crc_byte(crc_reg, i_lnk_data);
          p_cnt_next = p_cnt_reg - 16'h0001;
          if (p_cnt_reg == 16'h0001) begin
            p_state_next = P_FOOT;
            p_cnt_next = 16'h0000;
          end
        end
        P_FOOT: begin
          if (p_cnt_reg == 16'h0000) begin
            fcs_next = i_lnk_data;
            p_cnt_next = 16'h0001;
          end else begin
            // Footer arrives low byte first; payload is never used.
            if ({i_lnk_data, fcs_reg} != crc_reg)
              err_next[`DRA_EB_CRC] = 1'b1;
            p_state_next = P_HDR;
            p_cnt_next = 16'h0000;
          end
        end
        default: begin
          p_state_next = P_HDR;
        end
      endcase
    end
    // Burst end: a cut packet, or a missing end packet in an HS burst with end packets in use, is a violation.
    if (i_lnk_eot) begin
      if ((i_lnk_hs && ecfg_reg && !eots_next) ||
          p_state_next != P_HDR || p_cnt_next != 16'h0000)
        err_next[`DRA_EB_PROTO] = 1'b1;
      p_state_next = P_HDR;
      p_cnt_next = 16'h0000;
      eots_next = 1'b0;
    end
  end

  // Parser registers.
  always_ff @(posedge i_link_clock) begin
    if (lrst_reg) begin
      p_state_reg <= P_HDR;
      p_cnt_reg   <= 16'h0000;
      hdr_reg     <= 24'h000000;
      crc_reg     <= `DRA_CRC_SEED;
      fcs_reg     <= 8'h00;
      err_reg     <= 16'h0000;
      pend_reg    <= 1'b0;
      cmd_reg     <= 8'h00;
      mrs_reg     <= 16'h0001;
      eots_reg    <= 1'b0;
    end else begin
      p_state_reg <= p_state_next;
      p_cnt_reg   <= p_cnt_next;
      hdr_reg     <= hdr_next;
      crc_reg     <= crc_next;
      fcs_reg     <= fcs_next;
      err_reg     <= err_next;
      pend_reg    <= pend_next;
      cmd_reg     <= cmd_next;
      mrs_reg     <= mrs_next;
      eots_reg    <= eots_next;
    end
  end

  // Turnaround snapshot crosses into the answer clock.
  dra_word_sync #(.W($bits(dra_turn_t))) u_turn_sync (
    .i_src_clock (i_link_clock),
    .i_src_reset (lrst_reg),
    .i_src_load  (turn_load),
    .i_src_word  ({err_reg, pend_reg, cmd_reg, mrs_reg}),
    .o_src_busy  (sync_busy),
    .i_dst_clock (i_clock),
    .i_dst_reset (i_reset),
    .o_dst_valid (turn_valid),
    .o_dst_word  (turn_word)
  );

  // Answer side, on the device clock. Transmission is low-power only
  // and no end packet is ever built here.
  dra_sstate_t st_reg, st_next;           // Answer sequencer state.
  logic [1:0]  idx_reg, idx_next;         // Byte index within a group.
  logic [15:0] n_reg, n_next;             // Bytes to return.
  logic [15:0] rem_reg, rem_next;         // Payload bytes still to send.
  logic [23:0] pk_reg, pk_next;           // Header word being sent.
  logic        long_reg, long_next;       // Header opens a long packet.
  logic [15:0] rep_reg, rep_next;         // Error word to report.
  logic        rpend_reg, rpend_next;     // A report must still go out.
  logic [15:0] crct_reg, crct_next;       // Checksum of sent payload.
  logic [7:0]  txd_reg, txd_next;
  logic        txv_reg, txv_next;
  logic        txl_reg, txl_next;
  logic        rq_reg, rq_next;
  logic [7:0]  cmdo_reg, cmdo_next;
  logic [16:0] cnto_reg, cnto_next;
  logic        pop_reg, pop_next;
  logic        ack_reg, ack_next;
  logic        free, take;

  // A byte slot is free once the last one is taken; the cycle after a
  // pop is skipped so the source has time to advance.
  assign free = !txv_reg || i_tx_ready;
  assign take = i_rd_valid && !pop_reg;

  // Answer sequencer next-state.
  always_comb begin
    logic done;
    logic [15:0] n;
    done = 1'b0;
    n = (turn_word.max_ret == 16'h0000) ? 16'h0001 : turn_word.max_ret;
    st_next = st_reg;
    idx_next = idx_reg;
    n_next = n_reg;
    rem_next = rem_reg;
    pk_next = pk_reg;
    long_next = long_reg;
    rep_next = rep_reg;
    rpend_next = rpend_reg;
    crct_next = crct_reg;
    txd_next = txd_reg;
    txv_next = txv_reg && !i_tx_ready;
    txl_next = txl_reg && !i_tx_ready;
    rq_next = 1'b0;
    cmdo_next = cmdo_reg;
    cnto_next = cnto_reg;
    pop_next = 1'b0;
    ack_next = 1'b0;
    case (st_reg)
      S_IDLE: begin
        if (turn_valid) begin
          rep_next = turn_word.err & `DRA_REP_MASK;
          rpend_next = i_report_en && (turn_word.err != 16'h0000);
          // Built from the masked word, so bits 14 and 15 leave as zero.
          pk_next = {rep_next, `DRA_VC_MAIN, `DRA_DT_REPORT};
          long_next = 1'b0;
          idx_next = 2'h0;
          if (turn_word.rd_pend) begin
            n_next = n;
            rq_next = 1'b1;
            cmdo_next = turn_word.rd_cmd;
            cnto_next = {1'b0, n} + 17'h00001;
            st_next = S_SKIP;
          end else if (i_report_en && turn_word.err != 16'h0000) begin
            st_next = S_HDR;
          end else begin
            ack_next = 1'b1;
          end
        end
      end
      S_SKIP: begin
        if (take) begin
          pop_next = 1'b1;
          if (n_reg > `DRA_SHORT_MAX) begin
            pk_next = {n_reg, `DRA_VC_MAIN, `DRA_DT_RSPL};
            long_next = 1'b1;
            rem_next = n_reg;
            st_next = S_HDR;
          end else begin
            st_next = S_GET;
          end
        end
      end
      S_GET: begin
        if (take) begin
          pop_next = 1'b1;
          if (idx_reg == 2'h0) pk_next[23:8] = {8'h00, i_rd_data};
          else pk_next[23:16] = i_rd_data;
          if (idx_reg == 2'h1 || n_reg == 16'h0001) begin
            pk_next[7:0] = {`DRA_VC_MAIN, (n_reg == 16'h0001) ?
                            `DRA_DT_RSP1 : `DRA_DT_RSP2};
            idx_next = 2'h0;
            st_next = S_HDR;
          end else begin
            idx_next = 2'h1;
          end
        end
      end
      S_HDR: begin
        if (free) begin
          txv_next = 1'b1;
          idx_next = idx_reg + 2'h1;
          case (idx_reg)
            2'h0: txd_next = pk_reg[7:0];
            2'h1: txd_next = pk_reg[15:8];
            2'h2: txd_next = pk_reg[23:16];
            default: txd_next = {2'b00, dra_ecc(pk_reg)};
          endcase
          if (idx_reg == `DRA_HDR_LAST) begin
            crct_next = `DRA_CRC_SEED;
            if (long_reg) st_next = S_PAY;
            else begin
              txl_next = 1'b1;
              done = 1'b1;
            end
          end
        end
      end
      S_PAY: begin
        if (free && take) begin
          pop_next = 1'b1;
          txv_next = 1'b1;
          txd_next = i_rd_data;
          crct_next = dra_crc_byte(crct_reg, i_rd_data);
          rem_next = rem_reg - 16'h0001;
          if (rem_reg == 16'h0001) begin
            idx_next = 2'h0;
            st_next = S_CRC;
          end
        end
      end
      S_CRC: begin
        if (free) begin
          txv_next = 1'b1;
          txd_next = (idx_reg == 2'h0) ? crct_reg[7:0] : crct_reg[15:8];
          idx_next = 2'h1;
          if (idx_reg != 2'h0) begin
            txl_next = 1'b1;
            done = 1'b1;
          end
        end
      end
      default: begin
        st_next = S_IDLE;
      end
    endcase
    // After a data packet the pending report follows; after the report
    // the gathered flags are spent.
    if (done) begin
      idx_next = 2'h0;
      long_next = 1'b0;
      if (pk_reg[5:0] != `DRA_DT_REPORT && rpend_reg) begin
        pk_next = {rep_reg, `DRA_VC_MAIN, `DRA_DT_REPORT};
        st_next = S_HDR;
      end else begin
        rpend_next = 1'b0;
        st_next = S_IDLE;
      end
    end
  end

  // Answer sequencer registers.
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      st_reg <= S_IDLE;
      idx_reg <= 2'h0;
      n_reg <= 16'h0001;
      rem_reg <= 16'h0000;
      pk_reg <= 24'h000000;
      long_reg <= 1'b0;
      rep_reg <= 16'h0000;
      rpend_reg <= 1'b0;
      crct_reg <= `DRA_CRC_SEED;
      txd_reg <= 8'h00;
      txv_reg <= 1'b0;
      txl_reg <= 1'b0;
      rq_reg <= 1'b0;
      cmdo_reg <= 8'h00;
      cnto_reg <= 17'h00000;
      pop_reg <= 1'b0;
      ack_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      idx_reg <= idx_next;
      n_reg <= n_next;
      rem_reg <= rem_next;
      pk_reg <= pk_next;
      long_reg <= long_next;
      rep_reg <= rep_next;
      rpend_reg <= rpend_next;
      crct_reg <= crct_next;
      txd_reg <= txd_next;
      txv_reg <= txv_next;
      txl_reg <= txl_next;
      rq_reg <= rq_next;
      cmdo_reg <= cmdo_next;
      cnto_reg <= cnto_next;
      pop_reg <= pop_next;
      ack_reg <= ack_next;
    end
  end

  assign o_tx_data  = txd_reg;
  assign o_tx_valid = txv_reg;
  assign o_tx_last  = txl_reg;
  assign o_rd_req   = rq_reg;
  assign o_rd_cmd   = cmdo_reg;
  assign o_rd_count = cnto_reg;
  assign o_rd_pop   = pop_reg;
  assign o_ack      = ack_reg;
endmodule

// *** logic/dra_regs.svh ***
// Constants for the read, acknowledge and error-report packet logic.
`ifndef DRA_REGS_SVH
`define DRA_REGS_SVH
`define DRA_VC_MAIN    2'h0
`define DRA_DT_READ    6'h06
`define DRA_DT_MAXRET  6'h37
`define DRA_DT_EOT     6'h08
`define DRA_DT_NULL    6'h09
`define DRA_DT_WR0     6'h05
`define DRA_DT_WR1     6'h15
`define DRA_DT_WRL     6'h39
`define DRA_DT_REPORT  6'h02
`define DRA_DT_RSP1    6'h21
`define DRA_DT_RSP2    6'h22
`define DRA_DT_RSPL    6'h1C
`define DRA_EOT_BYTE   8'h0F
`define DRA_CRC_SEED   16'hFFFF
`define DRA_CRC_POLY   16'h8408
`define DRA_ECC_M0     24'hF12CB7
`define DRA_ECC_M1     24'hF2555B
`define DRA_ECC_M2     24'h749A6D
`define DRA_ECC_M3     24'hB8E38E
`define DRA_ECC_M4     24'hDF03F0
`define DRA_ECC_M5     24'hEFFC00
`define DRA_EB_ECC1    8
`define DRA_EB_ECC2    9
`define DRA_EB_CRC     10
`define DRA_EB_DTYPE   11
`define DRA_EB_VCID    12
`define DRA_EB_PROTO   13
`define DRA_REP_MASK   16'h3FFF
`define DRA_HDR_LAST   2'h3
`define DRA_SHORT_MAX  16'h0002
`define DRA_CMD_ERRCNT 8'h05
`define DRA_CMD_STAT_L 8'h0A
`define DRA_CMD_STAT_H 8'h0F
`define DRA_CMD_MEMRD  8'h2E
`define DRA_CMD_MEMRDC 8'h3E
`define DRA_CMD_BRIGHT 8'h52
`define DRA_CMD_CTRL   8'h54
`define DRA_CMD_CABC   8'h56
`define DRA_CMD_CABCMN 8'h5F
`define DRA_CMD_ID_L   8'hDA
`define DRA_CMD_ID_H   8'hDC
`endif

// *** logic/dra_pkg.sv ***
// Types and helper functions shared by the packet logic modules.
`include "dra_regs.svh"
package dra_pkg;
  // Snapshot handed from the link side to the answer side at turnaround.
  typedef struct packed {
    logic [15:0] err;
    logic        rd_pend;
    logic [7:0]  rd_cmd;
    logic [15:0] max_ret;
  } dra_turn_t;
  // Result of the header check: corrected word and error class.
  typedef struct packed {
    logic [23:0] word;
    logic        single;
    logic        multi;
  } dra_ecc_res_t;
  typedef enum logic [1:0] {P_HDR, P_PAY, P_FOOT} dra_pstate_t;
  typedef enum logic [2:0] {
    S_IDLE, S_SKIP, S_GET, S_HDR, S_PAY, S_CRC
  } dra_sstate_t;

  localparam logic [23:0] DRA_ECC_MASK [6] = '{`DRA_ECC_M0, `DRA_ECC_M1,
    `DRA_ECC_M2, `DRA_ECC_M3, `DRA_ECC_M4, `DRA_ECC_M5};

  // Six parity bits over the 24-bit header word.
  function automatic logic [5:0] dra_ecc(input logic [23:0] d);
    logic [5:0] p;
    for (int j = 0; j < 6; j++) p[j] = ^(d & DRA_ECC_MASK[j]);
    return p;
  endfunction

  // Syndrome check; a syndrome equal to a data column flips that bit.
  function automatic dra_ecc_res_t dra_ecc_fix(input logic [23:0] d,
                                               input logic [5:0] e);
    logic [5:0]   syn;
    logic [5:0]   col;
    dra_ecc_res_t r;
    syn = dra_ecc(d) ^ e;
    r.word = d;
    r.single = 1'b0;
    r.multi = 1'b0;
    if (syn != 6'h00) begin
      r.multi = ($countones(syn) != 1);
      r.single = !r.multi;
      for (int i = 0; i < 24; i++) begin
        for (int j = 0; j < 6; j++) col[j] = DRA_ECC_MASK[j][i];
        if (syn == col) begin
          r.word[i] = !d[i];
          r.single = 1'b1;
          r.multi = 1'b0;
        end
      end
    end
    return r;
  endfunction

  // One payload byte into the checksum. The register is held mirrored,
  // so the polynomial stands bit-reversed and the byte enters at bit 0;
  // a lone payload byte of 01h leaves 1E0Eh, as the host expects.
  function automatic logic [15:0] dra_crc_byte(input logic [15:0] c,
                                               input logic [7:0] b);
    logic [15:0] x;
    x = c;
    for (int i = 0; i < 8; i++)
      x = {1'b0, x[15:1]} ^ ((x[0] ^ b[i]) ? `DRA_CRC_POLY : 16'h0000);
    return x;
  endfunction

  // Read commands that the device answers.
  function automatic logic dra_cmd_ok(input logic [7:0] c);
    return (c == `DRA_CMD_ERRCNT) || (c == `DRA_CMD_MEMRD) ||
      (c >= `DRA_CMD_STAT_L && c <= `DRA_CMD_STAT_H) ||
      (c == `DRA_CMD_MEMRDC) || (c == `DRA_CMD_BRIGHT) ||
      (c == `DRA_CMD_CTRL) || (c == `DRA_CMD_CABC) ||
      (c == `DRA_CMD_CABCMN) ||
      (c >= `DRA_CMD_ID_L && c <= `DRA_CMD_ID_H);
  endfunction
endpackage

// *** logic/dra_word_sync.sv ***
// Toggle handshake that carries one word from one clock to another.
`timescale 1ns/1ps
module dra_word_sync #(
  parameter int W = 8
) (
  input  wire logic         i_src_clock,
  input  wire logic         i_src_reset,
  input  wire logic         i_src_load,
  input  wire logic [W-1:0] i_src_word,
  output logic              o_src_busy,
  input  wire logic         i_dst_clock,
  input  wire logic         i_dst_reset,
  output logic              o_dst_valid,
  output logic [W-1:0]      o_dst_word
);
  logic [W-1:0] hold_reg;      // Word held stable while in flight.
  logic         tog_reg;       // Flips once per loaded word.
  logic         ack_meta_reg;  // First stage of the returning toggle.
  logic         ack_sync_reg;  // Settled returning toggle.
  logic         req_meta_reg;  // First stage of the forward toggle.
  logic         req_sync_reg;  // Settled forward toggle.
  logic         req_seen_reg;  // Last forward toggle acted on.
  logic         val_reg;       // One-cycle arrival strobe.
  logic [W-1:0] word_reg;      // Word captured in the far domain.

  // Busy until the far side has echoed the toggle back.
  assign o_src_busy = tog_reg != ack_sync_reg;

  // Source side: a load while busy is dropped rather than corrupting.
  always_ff @(posedge i_src_clock) begin
    if (i_src_reset) begin
      hold_reg     <= '0;
      tog_reg      <= 1'b0;
      ack_meta_reg <= 1'b0;
      ack_sync_reg <= 1'b0;
    end else begin
      ack_meta_reg <= req_seen_reg;
      ack_sync_reg <= ack_meta_reg;
      if (i_src_load && !o_src_busy) begin
        hold_reg <= i_src_word;
        tog_reg  <= !tog_reg;
      end
    end
  end

  // Destination side: the word is stable once the toggle has settled.
  always_ff @(posedge i_dst_clock) begin
    if (i_dst_reset) begin
      req_meta_reg <= 1'b0;
      req_sync_reg <= 1'b0;
      req_seen_reg <= 1'b0;
      val_reg      <= 1'b0;
      word_reg     <= '0;
    end else begin
      req_meta_reg <= tog_reg;
      req_sync_reg <= req_meta_reg;
      req_seen_reg <= req_sync_reg;
      val_reg      <= req_sync_reg != req_seen_reg;
      if (req_sync_reg != req_seen_reg) word_reg <= hold_reg;
    end
  end

  assign o_dst_valid = val_reg;
  assign o_dst_word  = word_reg;
endmodule

// *** verification/dra_chk_properties.sv ***
// Checker on the ports of the read and report logic.
`timescale 1ns/1ps
module dra_chk (
  input logic i_clock, i_reset, i_tx_ready, o_tx_valid,
  input logic o_rd_req, o_rd_pop, o_ack, o_tx_last,
  input logic [7:0] o_tx_data,
  input logic [16:0] o_rd_count
);
  // One clock domain, so every check shares it and sleeps in reset.
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_reset);
  // High while the next byte offered opens a packet; payload bytes may
  // follow a gap in valid, so a rising valid alone is no packet start.
  logic sop_reg;
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      sop_reg <= 1'b1;
    end else if (o_tx_valid && i_tx_ready) begin
      sop_reg <= o_tx_last;
    end
  end
  a_tx_hold: assert property (
    o_tx_valid && !i_tx_ready |=> $stable(o_tx_data)) else $error("tx");
  a_pop_pulse: assert property (
    o_rd_pop |=> !o_rd_pop) else $error("pop");
  a_ack_alone: assert property (
    o_ack |-> !o_tx_valid && !o_rd_req) else $error("ack");
  a_count_dummy: assert property (
    o_rd_req |-> o_rd_count > 17'h00001) else $error("count");
  a_vc_zero: assert property (
    o_tx_valid && sop_reg |-> o_tx_data[7:6] == 2'h0) else $error("vc");
  a_no_eot: assert property (
    o_tx_valid && sop_reg |-> o_tx_data[5:0] != 6'h08) else $error("eot");
  a_req_first: assert property (
    o_rd_req |-> !o_tx_valid) else $error("req");
  a_pop_soon: assert property (
    o_rd_req |-> ##[1:200] o_rd_pop) else $error("no pop");
endmodule
bind dra_read_ack_top dra_chk u_chk (.*);

// *** verification/dra_host.sv ***
// Host model: header packets on a link clock that stops between bursts.
`timescale 1ns/1ps
`include "dra_regs.svh"
module dra_host (
  output logic o_clk, o_valid, o_eot, o_bta,
  output logic [7:0] o_data
);
  localparam logic [23:0] ecc_mask [6] = '{`DRA_ECC_M0, `DRA_ECC_M1,
    `DRA_ECC_M2, `DRA_ECC_M3, `DRA_ECC_M4, `DRA_ECC_M5};
  initial {o_clk, o_valid, o_eot, o_bta, o_data} = '0;
  // One link cycle; an idle line shows inverted data, never a stale byte.
  task automatic cy(input int v, e, b, d);
    {o_valid, o_eot, o_bta} = {v[0], e[0], b[0]};
    o_data = v[0] ? d[7:0] : ~o_data;
    #15 o_clk = 1'b1;
    #15 o_clk = 1'b0;
  endtask
  // Short header with the given data identifier, plus its check byte.
  task automatic sp(input logic [7:0] di, d0, d1);
    logic [7:0] b [4];
    b = '{di, d0, d1, 8'h00};
    for (int j = 0; j < 6; j++) b[3][j] = ^({d1, d0, di} & ecc_mask[j]);
    for (int k = 0; k < 4; k++) cy(1, 0, 0, int'(b[k]));
  endtask
endmodule

// *** verification/testbench.sv ***
// Bench for the read, answer and report logic.
`timescale 1ns/1ps
module testbench;
  logic i_clock = 0, i_reset = 1, i_report_en = 0, i_tx_ready = 0;
  logic i_eotp_used = 0, i_lnk_hs = 0, i_rd_valid = 1, o_tx_last;
  logic i_link_clock, i_lnk_valid, i_lnk_eot, i_lnk_bta, o_ack;
  logic o_tx_valid, o_rd_req, o_rd_pop;
  logic [7:0] i_lnk_data, o_tx_data, o_rd_cmd, tq[$];
  logic [7:0] i_lnk_phy_err = 8'h00, i_rd_data = 8'h40;
  logic [16:0] o_rd_count;
  int num_errors = 0, checks_done = 0, cyc = 0, acks = 0, lasts = 0;
  dra_host h (.o_clk(i_link_clock), .o_valid(i_lnk_valid),
    .o_eot(i_lnk_eot), .o_bta(i_lnk_bta), .o_data(i_lnk_data));
  dra_read_ack_top dut (.*);
  always #2 i_clock = ~i_clock;
  // Ready toggles so every answer byte after the first meets a stall.
  always @(posedge i_clock) begin
    cyc++;
    if (cyc == 20000) final_report(1);
    i_tx_ready <= #1 ~i_tx_ready;
    if (o_tx_valid && i_tx_ready) tq.push_back(o_tx_data);
    if (o_rd_pop) i_rd_data <= #1 i_rd_data + 8'h11;
    if (o_ack) acks++;
    if (o_tx_valid && i_tx_ready && o_tx_last) lasts++;
  end
  task automatic cmp(input logic [23:0] g, e);
    checks_done++;
    num_errors += int'(g !== e);
    if (g !== e) $display("BAD t=%0t got=%h exp=%h", $time, g, e);
  endtask
  // Ends the burst, turns the bus, waits for n bytes or an ack.
  task automatic run(input int n);
    tq.delete();
    acks = 0;
    lasts = 0;
    h.cy(0, 1, 0, 0);
    h.cy(0, 0, 1, 0);
    repeat (12) h.cy(0, 0, 0, 0);
    repeat (400) if (tq.size() < n && acks == 0) @(posedge i_clock);
  endtask
  task automatic t_read(input logic [7:0] n, c, dt, b0, b1);
    h.sp(8'h37, n, 8'h00);
    h.sp(8'h06, c, 8'h00);
    h.sp(8'h08, 8'h0F, 8'h0F);
    run(4);
    cmp({8'h00, o_rd_cmd, o_rd_count[7:0]}, {8'h00, c, n + 8'h01});
    cmp({tq[0], tq[1], tq[2]}, {dt, b0, b1});
    cmp(24'(lasts), 24'h000001);
    $display("read test done");
  endtask
  task automatic t_rep(input logic [7:0] di, d0, sz, a, hi);
    h.sp(di, d0, 8'h00);
    run(4);
    cmp({8'h00, 8'(acks), 8'(tq.size())}, {8'h00, a, sz});
    if (sz != 8'h00) cmp({tq[0], tq[1], tq[2]}, {8'h02, 8'h00, hi});
    cmp(24'(lasts), 24'(sz / 8'h04));
    $display("report test done");
  endtask
  // Null long packet with payload 01h; lo is the footer's low byte.
  task automatic t_null(input logic [7:0] lo, a, sz, hi);
    h.sp(8'h09, 8'h01, 8'h00);
    h.cy(1, 0, 0, 'h01);
    h.cy(1, 0, 0, int'(lo));
    h.cy(1, 0, 0, 'h1E);
    run(4);
    cmp({8'h00, 8'(acks), 8'(tq.size())}, {8'h00, a, sz});
    if (sz != 8'h00) cmp({tq[0], tq[1], tq[2]}, {8'h02, 8'h00, hi});
    $display("null test done");
  endtask
  task automatic final_report(input int t);
    num_errors += t;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (5) h.cy(0, 0, 0, 0);
    i_reset <= #1 1'b0;
    repeat (5) h.cy(0, 0, 0, 0);
    t_read(8'h01, 8'hDA, 8'h21, 8'h51, 8'h00);
    t_read(8'h02, 8'h2E, 8'h22, 8'h73, 8'h84);
    i_report_en <= #1 1'b1;
    t_rep(8'h46, 8'h0A, 8'h04, 8'h00, 8'h10);
    t_rep(8'h06, 8'h01, 8'h00, 8'h01, 8'h00);
    t_null(8'h0E, 8'h01, 8'h00, 8'h00);
    t_null(8'h0F, 8'h00, 8'h04, 8'h04);
    i_lnk_hs <= #1 1'b1;
    i_eotp_used <= #1 1'b1;
    t_rep(8'h05, 8'h11, 8'h04, 8'h00, 8'h20);
    final_report(0);
  end
endmodule
